// ==== hdl/scwp_pkg.sv ====
// Constants and types shared by both ends of the serial configuration write port
package scwp_pkg;

    localparam int unsigned FRAME_W       = 32;
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned BANK_LSB      = 3;
    localparam int unsigned IDX_W         = 3;
    localparam int unsigned NUM_REGS      = 32;

    localparam logic [1:0] BANK_EEPROM    = 2'h0;
    localparam logic [1:0] BANK_TX_SYNTH  = 2'h1;
    localparam logic [1:0] BANK_RX_SYNTH  = 2'h2;
    localparam logic [1:0] BANK_TXRX      = 2'h3;

    localparam logic [3:0] SIZE_EEPROM    = 4'h3;
    localparam logic [3:0] SIZE_SYNTH     = 4'h6;
    localparam logic [3:0] SIZE_TXRX      = 4'h8;

    // Control register 0: readback request bit and target address
    localparam logic [2:0] IDX_SPECIAL    = 3'h0;
    localparam int unsigned RB_REQ_BIT    = 5;
    localparam int unsigned RB_ADDR_LSB   = 6;
    // Sclk edges spent crossing the readback word before bit 0 appears
    localparam int unsigned RB_LEAD       = 2;

    localparam logic [31:0] REG_RST      = 32'h0000_0000;
    // Frame that addresses nothing: eeprom bank, index 7
    localparam logic [31:0] NOOP_FRAME   = 32'h0000_0007;

    // Link timing in ns, converted to mclk cycles
    localparam int unsigned MCLK_PS       = 4000;
    localparam int unsigned T_CLK_NS      = 50;
    localparam int unsigned T_SU2_NS      = 20;
    localparam int unsigned T_W_NS        = 50;
    localparam int unsigned T_SU3_NS      = 70;
    localparam int unsigned HALF_CYC      = ((T_CLK_NS * 500) + MCLK_PS - 1) / MCLK_PS;
    localparam int unsigned SU2_CYC       = ((T_SU2_NS * 1000) + MCLK_PS - 1) / MCLK_PS;
    localparam int unsigned W_CYC         = ((T_W_NS * 1000) + MCLK_PS - 1) / MCLK_PS;
    localparam int unsigned SU3_CYC       = ((T_SU3_NS * 1000) + MCLK_PS - 1) / MCLK_PS;

    typedef enum logic [2:0] {
        SCWP_IDLE   = 3'h0,
        SCWP_SHIFT  = 3'h1,
        SCWP_SETUP  = 3'h3,
        SCWP_STROBE = 3'h2,
        SCWP_GAP    = 3'h6,
        SCWP_RBACK  = 3'h7
    } scwp_state_t;

    function automatic logic [3:0] scwp_bank_size(input logic [1:0] bank);
        unique case (bank)
            BANK_EEPROM:   scwp_bank_size = SIZE_EEPROM;
            BANK_TX_SYNTH: scwp_bank_size = SIZE_SYNTH;
            BANK_RX_SYNTH: scwp_bank_size = SIZE_SYNTH;
            BANK_TXRX:     scwp_bank_size = SIZE_TXRX;
        endcase
    endfunction

endpackage

// ==== hdl/scwp_if.sv ====
// Serial link wires between the host end and the device end
`timescale 1ns/100ps
interface scwp_if;
    logic serial_clock_pin;
    logic serial_data_pin;
    logic latch_strobe_pin;
    logic readback_output_pin;

    modport dev (
        input  serial_clock_pin,
        input  serial_data_pin,
        input  latch_strobe_pin,
        output readback_output_pin
    );

    modport host (
        output serial_clock_pin,
        output serial_data_pin,
        output latch_strobe_pin,
        input  readback_output_pin
    );
endinterface

// ==== hdl/scwp_device.sv ====
// Device end: serial shift register, register banks and readback shifter
`timescale 1ns/100ps
module scwp_device
    import scwp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    scwp_if.dev              link,
    input  wire logic [4:0]  usr_rd_addr,
    output logic      [31:0] usr_rd_data,
    output logic             usr_wr_stb,
    output logic      [4:0]  usr_wr_addr,
    output logic      [31:0] usr_wr_data
);

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain
    logic [FRAME_W-1:0] shift_ff;
    logic               lrst_s1_ff;
    logic               lrst_s2_ff;
    logic               tog_s1_ff;
    logic               tog_s2_ff;
    logic               seen_ff;
    logic [FRAME_W-1:0] rb_shift_ff;
    logic               rdbk_ff;

    // Shift register; no reset, every frame overwrites it whole
    always_ff @(posedge link.serial_clock_pin) begin
        shift_ff <= {link.serial_data_pin, shift_ff[FRAME_W-1:1]};
    end

    always_ff @(posedge link.serial_clock_pin) begin
        lrst_s1_ff <= srst;
        lrst_s2_ff <= lrst_s1_ff;
    end

    logic rb_tog_ff;
    logic [FRAME_W-1:0] rb_word_ff;

    always_ff @(posedge link.serial_clock_pin) begin
        if (lrst_s2_ff) begin
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
        end else begin
            tog_s1_ff <= rb_tog_ff;
            tog_s2_ff <= tog_s1_ff;
        end
    end

    // No reset: sclk stands still during srst, so edge history settles itself
    always_ff @(posedge link.serial_clock_pin) begin
        seen_ff <= tog_s2_ff;
    end

    // Word is static once the toggle is seen, so it crosses as a bundle
    always_ff @(posedge link.serial_clock_pin) begin
        if (lrst_s2_ff) begin
            rb_shift_ff <= REG_RST;
            rdbk_ff     <= 1'b0;
        end else if (tog_s2_ff != seen_ff) begin
            rb_shift_ff <= {1'b0, rb_word_ff[FRAME_W-1:1]};
            rdbk_ff     <= rb_word_ff[0];
        end else begin
            rb_shift_ff <= {1'b0, rb_shift_ff[FRAME_W-1:1]};
            rdbk_ff     <= rb_shift_ff[0];
        end
    end

    assign link.readback_output_pin = rdbk_ff;

    ////////////////////////////////////////////////////////////////////////
    // System clock domain
    logic ls_s1_ff;
    logic ls_s2_ff;
    logic ls_s3_ff;
    logic latch_evt;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ls_s1_ff <= 1'b0;
            ls_s2_ff <= 1'b0;
            ls_s3_ff <= 1'b0;
        end else begin
            ls_s1_ff <= link.latch_strobe_pin;
            ls_s2_ff <= ls_s1_ff;
            ls_s3_ff <= ls_s2_ff;
        end
    end

    // Strobe has no relation to sclk, so its edge is found on mclk
    assign latch_evt = ls_s2_ff & ~ls_s3_ff;

    logic [1:0]        frm_bank;
    logic [2:0]        frm_idx;
    logic [ADDR_W-1:0] frm_addr;
    logic              frm_ok;
    logic              frm_rb;
    logic [ADDR_W-1:0] frm_rb_addr;

    // Shift register is quiet while the strobe is high, held by the host
    assign frm_bank    = shift_ff[ADDR_W-1:BANK_LSB];
    assign frm_idx     = shift_ff[IDX_W-1:0];
    assign frm_addr    = shift_ff[ADDR_W-1:0];
    assign frm_ok      = {1'b0, frm_idx} < scwp_bank_size(frm_bank);
    assign frm_rb      = (frm_bank == BANK_TXRX) && (frm_idx == IDX_SPECIAL)
                         && shift_ff[RB_REQ_BIT];
    assign frm_rb_addr = shift_ff[RB_ADDR_LSB +: ADDR_W];

    logic [FRAME_W-1:0] regs_ff [NUM_REGS];

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= REG_RST;
            end
        end else if (latch_evt && frm_ok) begin
            regs_ff[frm_addr] <= shift_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            usr_wr_stb  <= 1'b0;
            usr_wr_addr <= 5'h00;
            usr_wr_data <= REG_RST;
        end else begin
            usr_wr_stb <= latch_evt && frm_ok;
            if (latch_evt && frm_ok) begin
                usr_wr_addr <= frm_addr;
                usr_wr_data <= shift_ff;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            usr_rd_data <= REG_RST;
        end else begin
            usr_rd_data <= regs_ff[usr_rd_addr];
        end
    end

    // Readback request snapshots the target and flips the toggle in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            rb_word_ff <= REG_RST;
            rb_tog_ff  <= 1'b0;
        end else if (latch_evt && frm_rb) begin
            rb_word_ff <= regs_ff[frm_rb_addr];
            rb_tog_ff  <= ~rb_tog_ff;
        end
    end

endmodule // scwp_device

// ==== hdl/scwp_host.sv ====
// Host end: frames commands onto the serial link and collects readback
`timescale 1ns/100ps
module scwp_host
    import scwp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    scwp_if.host             link,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [31:0] cmd_word,
    output logic             rsp_valid,
    output logic      [31:0] rsp_data
);

    localparam logic [5:0] HALF_M1 = 6'(HALF_CYC - 1);
    localparam logic [5:0] SU2_M1  = 6'(SU2_CYC - 1);
    localparam logic [5:0] W_M1    = 6'(W_CYC - 1);
    localparam logic [5:0] SU3_M1  = 6'(SU3_CYC - 1);
    localparam logic [5:0] BITS_M1 = 6'(FRAME_W - 1);
    localparam logic [5:0] RB_M1   = 6'(FRAME_W + RB_LEAD - 1);
    localparam logic [5:0] LEAD    = 6'(RB_LEAD);

    initial begin
        if (HALF_CYC > 63 || SU3_CYC > 63) $error("scwp_host: timing count too large");
    end

    scwp_state_t        state_ff;
    logic [5:0]         cnt_ff;
    logic [5:0]         bit_ff;
    logic [FRAME_W-1:0] tx_ff;
    logic [FRAME_W-1:0] rx_ff;
    logic               rd_pend_ff;
    logic               sclk_ff;
    logic               sdata_ff;
    logic               strobe_ff;
    logic               rb_s1_ff;
    logic               rb_s2_ff;
    logic               cnt_done;
    logic               last_bit;

    assign cnt_done = (cnt_ff == 6'h00);
    assign last_bit = (state_ff == SCWP_RBACK) ? (bit_ff == RB_M1) : (bit_ff == BITS_M1);

    ////////////////////////////////////////////////////////////////////////
    // Readback pin synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            rb_s1_ff <= 1'b0;
            rb_s2_ff <= 1'b0;
        end else begin
            rb_s1_ff <= link.readback_output_pin;
            rb_s2_ff <= rb_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff   <= SCWP_IDLE;
            cnt_ff     <= 6'h00;
            bit_ff     <= 6'h00;
            tx_ff      <= REG_RST;
            rx_ff      <= REG_RST;
            rd_pend_ff <= 1'b0;
            sclk_ff    <= 1'b0;
            sdata_ff   <= 1'b0;
            strobe_ff  <= 1'b0;
            cmd_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_data   <= REG_RST;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state_ff)
                SCWP_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready  <= 1'b0;
                        rd_pend_ff <= cmd_read;
                        // Readback asks control register 0 for the target word
                        tx_ff      <= cmd_read ? (32'(cmd_word[ADDR_W-1:0]) << RB_ADDR_LSB)
                                                 | (32'h1 << RB_REQ_BIT)
                                                 | 32'(BANK_TXRX) << BANK_LSB
                                                 | 32'(IDX_SPECIAL)
                                               : cmd_word;
                        sdata_ff   <= cmd_read ? 1'b0 : cmd_word[0];
                        bit_ff     <= 6'h00;
                        cnt_ff     <= HALF_M1;
                        state_ff   <= SCWP_SHIFT;
                    end
                end
                SCWP_SHIFT, SCWP_RBACK: begin
                    cnt_ff <= cnt_done ? HALF_M1 : cnt_ff - 6'h01;
                    if (cnt_done && !sclk_ff) begin
                        sclk_ff <= 1'b1;
                    end else if (cnt_done) begin
                        // Sample at end of high phase, data settled by then
                        if (state_ff == SCWP_RBACK && bit_ff >= LEAD) begin
                            rx_ff <= {rb_s2_ff, rx_ff[FRAME_W-1:1]};
                        end
                        sclk_ff <= 1'b0;
                        bit_ff  <= bit_ff + 6'h01;
                        if (last_bit && state_ff == SCWP_SHIFT) begin
                            cnt_ff   <= SU2_M1;
                            state_ff <= SCWP_SETUP;
                        end else if (last_bit) begin
                            rsp_valid  <= 1'b1;
                            rsp_data   <= {rb_s2_ff, rx_ff[FRAME_W-1:1]};
                            rd_pend_ff <= 1'b0;
                            state_ff   <= SCWP_IDLE;
                        end else begin
                            sdata_ff <= tx_ff[5'(bit_ff + 6'h01)];
                        end
                    end
                end
                SCWP_SETUP: begin
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_done) begin
                        strobe_ff <= 1'b1;
                        cnt_ff    <= W_M1;
                        state_ff  <= SCWP_STROBE;
                    end
                end
                SCWP_STROBE: begin
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_done) begin
                        strobe_ff <= 1'b0;
                        cnt_ff    <= SU3_M1;
                        state_ff  <= SCWP_GAP;
                    end
                end
                SCWP_GAP: begin
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_done && rd_pend_ff) begin
                        // Unlatched no-op frame clocks the readback word out
                        tx_ff    <= NOOP_FRAME;
                        sdata_ff <= NOOP_FRAME[0];
                        bit_ff   <= 6'h00;
                        cnt_ff   <= HALF_M1;
                        state_ff <= SCWP_RBACK;
                    end else if (cnt_done) begin
                        state_ff <= SCWP_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.serial_clock_pin = sclk_ff;
    assign link.serial_data_pin  = sdata_ff;
    assign link.latch_strobe_pin = strobe_ff;

endmodule // scwp_host

// ==== tb/scwp_monitor.sv ====
// Concurrent checks on the serial link and the device write strobe
`timescale 1ns/100ps
module scwp_monitor (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       serial_clock_pin,
    input wire logic       serial_data_pin,
    input wire logic       latch_strobe_pin,
    input wire logic       readback_output_pin,
    input wire logic       usr_wr_stb,
    input wire logic [4:0] usr_wr_addr
);
    logic        sclk_ff;
    logic [31:0] frame_ff;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////
    // Own copy of the frame, sampled where the device samples it
    always_ff @(posedge mclk) begin
        sclk_ff <= serial_clock_pin;
    end

    always_ff @(posedge mclk) begin
        if (serial_clock_pin && !sclk_ff) begin
            frame_ff <= {serial_data_pin, frame_ff[31:1]};
        end
    end

    function automatic logic idx_ok(input logic [4:0] a);
        case (a[4:3])
            2'h0:    idx_ok = (a[2:0] < 3'h3);
            2'h3:    idx_ok = 1'b1;
            default: idx_ok = (a[2:0] < 3'h6);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    AST_SCLK_HIGH: assert property ($rose(serial_clock_pin) |->
        serial_clock_pin [*7] ##1 !serial_clock_pin) else $error("sclk high phase wrong");
    AST_DATA_HOLD: assert property (serial_clock_pin && $past(serial_clock_pin) |->
        $stable(serial_data_pin)) else $error("data moved in sclk high");
    AST_STROBE_QUIET: assert property (latch_strobe_pin |-> !serial_clock_pin)
        else $error("sclk active while strobe high");
    AST_STROBE_WIDTH: assert property ($rose(latch_strobe_pin) |->
        latch_strobe_pin [*8]) else $error("strobe too short");
    AST_STROBE_SETUP: assert property ($rose(latch_strobe_pin) |->
        !$past(serial_clock_pin) && !$past(serial_clock_pin, 4)) else $error("strobe setup");
    AST_GAP_AFTER: assert property ($fell(latch_strobe_pin) |->
        !serial_clock_pin [*8]) else $error("sclk too soon after strobe");
    AST_WR_PULSE: assert property (usr_wr_stb |=> !usr_wr_stb)
        else $error("write pulse longer than one cycle");
    AST_WR_CAUSE: assert property (usr_wr_stb |->
        latch_strobe_pin && $past(latch_strobe_pin)) else $error("write without strobe");
    AST_WR_RANGE: assert property (usr_wr_stb |-> idx_ok(usr_wr_addr))
        else $error("write to missing register");
    AST_WR_AFTER: assert property ($rose(latch_strobe_pin) && idx_ok(frame_ff[4:0]) |->
        ##[2:6] (usr_wr_stb && usr_wr_addr == frame_ff[4:0])) else $error("frame not written");
    AST_RB_EDGE: assert property ($changed(readback_output_pin) |->
        $rose(serial_clock_pin)) else $error("readback moved off sclk rise");
endmodule // scwp_monitor

// ==== tb/serial_config_write_port_tb_top.sv ====
// Bench joining host end and device end over the serial link
`timescale 1ns/100ps
module serial_config_write_port_tb_top;
    import scwp_pkg::*;

    logic        mclk = 1'b0;
    logic        srst;
    logic        cmd_valid;
    logic        cmd_ready;
    logic        cmd_read;
    logic [31:0] cmd_word;
    logic        rsp_valid;
    logic [31:0] rsp_data;
    logic [4:0]  usr_rd_addr;
    logic [31:0] usr_rd_data;
    logic        usr_wr_stb;
    logic [4:0]  usr_wr_addr;
    logic [31:0] usr_wr_data;
    logic [31:0] sniff_sr;
    logic [31:0] sniff_frame;
    logic [31:0] sniff_n = 32'h0;
    logic [31:0] sniff_base = 32'h0;
    logic [31:0] sniff_edges;
    logic [31:0] rsp_seen;
    int          wr_pulses = 0;
    int          rsp_cnt = 0;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #2 mclk = ~mclk;

    scwp_if link_if ();
    scwp_host scwp_host_inst (.mclk(mclk), .srst(srst), .link(link_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    scwp_device scwp_device_inst (.mclk(mclk), .srst(srst), .link(link_if),
        .usr_rd_addr(usr_rd_addr), .usr_rd_data(usr_rd_data), .usr_wr_stb(usr_wr_stb),
        .usr_wr_addr(usr_wr_addr), .usr_wr_data(usr_wr_data));
    scwp_monitor scwp_monitor_inst (.mclk(mclk), .srst(srst),
        .serial_clock_pin(link_if.serial_clock_pin),
        .serial_data_pin(link_if.serial_data_pin),
        .latch_strobe_pin(link_if.latch_strobe_pin),
        .readback_output_pin(link_if.readback_output_pin),
        .usr_wr_stb(usr_wr_stb), .usr_wr_addr(usr_wr_addr));

    ////////////////////////////////////////////////////////////////////////////
    // Wire sniffer, independent of the device's own shifter
    always @(posedge link_if.serial_clock_pin) begin
        sniff_sr = {link_if.serial_data_pin, sniff_sr[31:1]};
        sniff_n = sniff_n + 32'h1;
    end

    always @(posedge link_if.latch_strobe_pin) begin
        sniff_frame = sniff_sr;
        sniff_edges = sniff_n - sniff_base;
        sniff_base = sniff_n;
    end

    always @(posedge mclk) begin
        if (usr_wr_stb === 1'b1) wr_pulses <= wr_pulses + 1;
        if (rsp_valid === 1'b1) begin
            rsp_seen <= rsp_data;
            rsp_cnt <= rsp_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bit 5 kept clear so a control reg 0 write never asks for readback
    function automatic logic [31:0] frame_of(input logic [4:0] a);
        frame_of = {20'hC3A59 + 20'(a), 7'h02, a};
    endfunction

    function automatic logic ok_of(input logic [4:0] a);
        ok_of = (a[4:3] == 2'h0) ? (a[2:0] < 3'h3) : (a[4:3] == 2'h3) ? 1'b1 : (a[2:0] < 3'h6);
    endfunction

    task automatic do_cmd(input logic rd, input logic [31:0] w);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_word = w;
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    task automatic read_reg(input logic [4:0] a, input logic [31:0] exp, input string what);
        usr_rd_addr = a;
        repeat (2) @(posedge mclk);
        #1;
        check(what, usr_rd_data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Every address of every bank, back to back
    task automatic sc_banks;
        logic [4:0] a;
        int         p;
        for (int i = 0; i < 32; i++) begin
            a = 5'(i);
            p = wr_pulses;
            do_cmd(1'b0, frame_of(a));
            check("frame on wire", sniff_frame, frame_of(a));
            check("edges per frame", sniff_edges, 32'h20);
            check("write pulses", 32'(wr_pulses - p), {31'h0, ok_of(a)});
            if (ok_of(a)) begin
                check("write address", {27'h0, usr_wr_addr}, {27'h0, a});
                check("write data", usr_wr_data, frame_of(a));
            end
            read_reg(a, ok_of(a) ? frame_of(a) : REG_RST, "stored value");
        end
    endtask

    // Readback of stored and missing registers, control reg 0 checked after each
    task automatic sc_readback;
        logic [4:0]  ra [3];
        logic [31:0] e;
        int          c;
        ra = '{5'h0D, 5'h1F, 5'h05};
        for (int k = 0; k < 3; k++) begin
            e = (k == 2) ? REG_RST : frame_of(ra[k]);
            c = rsp_cnt;
            do_cmd(1'b1, {27'h0, ra[k]});
            check("readback pulses", 32'(rsp_cnt - c), 32'h1);
            check("readback word", rsp_seen, e);
            read_reg(5'h18, {21'h0, ra[k], 1'b1, 5'h18}, "control reg 0");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_word = 32'h0;
        usr_rd_addr = 5'h0;
        repeat (4) @(posedge mclk);
        #1;
        srst = 1'b0;
        sc_banks();
        sc_readback();
        close_out();
    end

    // Whole run needs some 20000 cycles; twice that means a hang
    initial begin
        #160000;
        miscompares++;
        close_out();
    end
endmodule // serial_config_write_port_tb_top
